// file: harmonic_overcurrent_block.sv
// Four harmonic overcurrent stages behind an AXI4-Lite register slave.
// Assumes the front end streams magnitudes on aclk and pulses frame
// once per 5 ms after the last value of that frame.
`timescale 1ns/1ns
`default_nettype none
module harmonic_overcurrent_block
	import hoc_pkg::*;
(
	// Clock and reset
	input  wire logic              aclk,
	input  wire logic              aresetn,
	// AXI4-Lite write
	input  wire logic [ADDR_W-1:0] s_axi_awaddr,
	input  wire logic              s_axi_awvalid,
	output var  logic              s_axi_awready,
	input  wire logic [31:0]       s_axi_wdata,
	input  wire logic [3:0]        s_axi_wstrb,
	input  wire logic              s_axi_wvalid,
	output var  logic              s_axi_wready,
	output var  logic [1:0]        s_axi_bresp,
	output var  logic              s_axi_bvalid,
	input  wire logic              s_axi_bready,
	// AXI4-Lite read
	input  wire logic [ADDR_W-1:0] s_axi_araddr,
	input  wire logic              s_axi_arvalid,
	output var  logic              s_axi_arready,
	output var  logic [31:0]       s_axi_rdata,
	output var  logic [1:0]        s_axi_rresp,
	output var  logic              s_axi_rvalid,
	input  wire logic              s_axi_rready,
	// Measurement stream
	input  wire logic              meas_valid,
	input  wire logic              meas_side,
	input  wire logic [2:0]        meas_chan,
	input  wire logic [4:0]        meas_order,
	input  wire logic [15:0]       meas_value,
	input  wire logic              meas_frame,
	// Blocking inputs and stage outputs
	input  wire logic [NSTAGE-1:0] block_in,
	output var  logic [NSTAGE-1:0] start_out,
	output var  logic [NSTAGE-1:0] trip_out,
	output var  logic [NSTAGE-1:0] blocked_out
);
	// -------------------------------------------------------------------
	// Register slave
	// -------------------------------------------------------------------
	logic [ADDR_W-1:0] aw_addr_reg;
	logic              aw_full_reg;
	logic [31:0]       w_data_reg;
	logic [3:0]        w_strb_reg;
	logic              w_full_reg;
	logic              bvalid_reg;
	logic [1:0]        bresp_reg;
	logic              rvalid_reg;
	logic [31:0]       rdata_reg;
	logic [1:0]        rresp_reg;
	logic [31:0]       cfg_reg [NSTAGE];
	logic [15:0]       pu_reg  [NSTAGE];
	logic [15:0]       pct_reg [NSTAGE];
	logic [18:0]       dly_reg [NSTAGE];
	logic [1:0]        glb_reg;
	logic [31:0]       stat_w  [NSTAGE];
	logic [31:0]       ratio_w [NSTAGE];
	logic [31:0]       remain_w[NSTAGE];
	logic [31:0]       expect_w[NSTAGE];
	logic [NSTAGE-1:0] blk_sync;

	wire               do_write = aw_full_reg & w_full_reg & ~bvalid_reg;
	wire [1:0]         wr_stage = aw_addr_reg[6:5];
	wire [7:0]         wr_off   = {3'b000, aw_addr_reg[4:2], 2'b00};
	wire               wr_stg   = ~aw_addr_reg[7];
	wire               wr_glb   = aw_addr_reg == OFF_GLOBAL;
	wire [31:0]        wmask    = {{8{w_strb_reg[3]}}, {8{w_strb_reg[2]}},
		{8{w_strb_reg[1]}}, {8{w_strb_reg[0]}}};
	wire [31:0]        wr_old   = (wr_off == OFF_PU) ? 32'(pu_reg[wr_stage]) :
		(wr_off == OFF_PCT) ? 32'(pct_reg[wr_stage]) :
		(wr_off == OFF_DLY) ? 32'(dly_reg[wr_stage]) : cfg_reg[wr_stage];
	wire [31:0]        wr_val   = (wr_old & ~wmask) | (w_data_reg & wmask);
	wire [15:0]        wr_lo    = wr_val[15:0];
	wire               rd_take  = s_axi_arvalid & ~rvalid_reg;
	wire [1:0]         rd_stage = s_axi_araddr[6:5];
	wire [7:0]         rd_off   = {3'b000, s_axi_araddr[4:2], 2'b00};
	wire               rd_stg   = ~s_axi_araddr[7];
	wire               rd_glb   = s_axi_araddr == OFF_GLOBAL;
	wire [31:0]        rd_stg_v =
		(rd_off == OFF_CFG)    ? cfg_reg[rd_stage] :
		(rd_off == OFF_PU)     ? 32'(pu_reg[rd_stage]) :
		(rd_off == OFF_PCT)    ? 32'(pct_reg[rd_stage]) :
		(rd_off == OFF_DLY)    ? 32'(dly_reg[rd_stage]) :
		(rd_off == OFF_STAT)   ? stat_w[rd_stage] :
		(rd_off == OFF_RATIO)  ? ratio_w[rd_stage] :
		(rd_off == OFF_REMAIN) ? remain_w[rd_stage] : expect_w[rd_stage];
	wire [31:0]        rd_val   = rd_stg ? rd_stg_v :
		rd_glb ? 32'(glb_reg) : 32'h0000_0000;

	assign s_axi_awready = ~aw_full_reg;
	assign s_axi_wready  = ~w_full_reg;
	assign s_axi_bvalid  = bvalid_reg;
	assign s_axi_bresp   = bresp_reg;
	assign s_axi_arready = ~rvalid_reg;
	assign s_axi_rvalid  = rvalid_reg;
	assign s_axi_rdata   = rdata_reg;
	assign s_axi_rresp   = rresp_reg;

	// Address and data may arrive in either order
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			aw_full_reg <= 1'b0;
			aw_addr_reg <= '0;
			w_full_reg  <= 1'b0;
			w_data_reg  <= '0;
			w_strb_reg  <= '0;
		end else begin
			if (s_axi_awvalid & ~aw_full_reg) begin
				aw_full_reg <= 1'b1;
				aw_addr_reg <= s_axi_awaddr;
			end else if (do_write) begin
				aw_full_reg <= 1'b0;
			end
			if (s_axi_wvalid & ~w_full_reg) begin
				w_full_reg <= 1'b1;
				w_data_reg <= s_axi_wdata;
				w_strb_reg <= s_axi_wstrb;
			end else if (do_write) begin
				w_full_reg <= 1'b0;
			end
		end
	end

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			bvalid_reg <= 1'b0;
			bresp_reg  <= RESP_OKAY;
		end else if (do_write) begin
			bvalid_reg <= 1'b1;
			bresp_reg  <= (wr_stg | wr_glb) ? RESP_OKAY : RESP_SLVERR;
		end else if (s_axi_bready) begin
			bvalid_reg <= 1'b0;
		end
	end

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			rvalid_reg <= 1'b0;
			rdata_reg  <= '0;
			rresp_reg  <= RESP_OKAY;
		end else if (rd_take) begin
			rvalid_reg <= 1'b1;
			rdata_reg  <= rd_val;
			rresp_reg  <= (rd_stg | rd_glb) ? RESP_OKAY : RESP_SLVERR;
		end else if (s_axi_rready) begin
			rvalid_reg <= 1'b0;
		end
	end

	// Settings; levels are clamped to their legal span on write
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			glb_reg <= GLB_RST;
			for (int i = 0; i < NSTAGE; i++) begin
				cfg_reg[i] <= CFG_RST;
				pu_reg[i]  <= PU_RST;
				pct_reg[i] <= PCT_RST;
				dly_reg[i] <= DLY_RST;
			end
		end else if (do_write & wr_glb) begin
			glb_reg <= wr_val[1:0];
		end else if (do_write & wr_stg) begin
			unique case (wr_off)
				OFF_CFG: cfg_reg[wr_stage] <= {18'h0, wr_val[13:0]};
				OFF_PU: pu_reg[wr_stage] <= (wr_lo < PU_MIN) ? PU_MIN :
					(wr_lo > PU_MAX) ? PU_MAX : wr_lo;
				OFF_PCT: pct_reg[wr_stage] <= (wr_lo < PCT_MIN) ? PCT_MIN :
					(wr_lo > PCT_MAX) ? PCT_MAX : wr_lo;
				OFF_DLY: dly_reg[wr_stage] <= (wr_val[18:0] > MAX_TICKS) ?
					MAX_TICKS : wr_val[18:0];
				default: ;
			endcase
		end
	end

	hoc_sync #(.W(NSTAGE)) u_blk_sync (
		.aclk    (aclk),
		.aresetn (aresetn),
		.din     (block_in),
		.dout    (blk_sync)
	);

	// -------------------------------------------------------------------
	// Stages, each with its own settings and evaluator
	// -------------------------------------------------------------------
	genvar g;
	for (g = 0; g < NSTAGE; g++) begin : stg
		logic [15:0] h_reg [3];
		logic [15:0] f_reg [3];
		eval_e       st_reg;
		logic [1:0]  ph_reg;
		logic [23:0] m_reg;
		logic [23:0] rmax_reg;
		logic        over_reg;
		logic        hold_reg;
		logic        pick_reg;
		logic        blkd_reg;
		logic        start_reg;
		logic        trip_reg;
		logic [18:0] elap_reg;
		logic [23:0] ratio_reg;
		logic [18:0] expect_reg;
		logic        so_reg;
		logic        to_reg;
		logic        bo_reg;
		logic        div_done;
		logic [31:0] div_quo;

		wire [31:0] cfg    = cfg_reg[g];
		wire        pct    = cfg[CFG_PCT_BIT];
		wire [1:0]  inp    = cfg[CFG_INP_LSB +: 2];
		wire [2:0]  cmode  = cfg[CFG_MODE_LSB +: 3];
		wire [1:0]  fcode  = cfg[CFG_FORCE_LSB +: 2];
		wire [4:0]  horder = harm_order(cfg[CFG_HARM_LSB +: 4]);
		wire [2:0]  res_ch = (inp == INP_RES1) ? CH_RES1 : CH_RES2;
		wire        ch_hit = (inp == INP_PHASE) ? (meas_chan <= CH_L3) :
			(meas_chan == res_ch);
		wire [1:0]  slot   = (inp == INP_PHASE) ? meas_chan[1:0] : 2'h0;
		wire        take   = meas_valid & ch_hit &
			(meas_side == cfg[CFG_SIDE_BIT]);
		wire [1:0]  last   = (inp == INP_PHASE) ? 2'h2 : 2'h0;
		wire [15:0] lvl    = pct ? pct_reg[g] : pu_reg[g];
		wire        legal  = (cmode >= MODE_ON) & (cmode <= MODE_OFF);
		wire [2:0]  emode  = (glb_reg[GLB_MODE_BIT] & legal) ? cmode :
			MODE_ON;
		wire        off    = emode == MODE_OFF;
		wire        blk    = blk_sync[g] | (emode == MODE_BLK) |
			(emode == MODE_TBLK);
		wire        div_go = ((st_reg == S_MEAS) & pct) | (st_reg == S_RAT);
		wire [31:0] div_n  = (st_reg == S_MEAS) ?
			32'(h_reg[ph_reg]) * PCT_SCALE : 32'(m_reg) * RATIO_SCALE;
		wire [15:0] div_d  = (st_reg == S_MEAS) ? f_reg[ph_reg] : lvl;
		wire [23:0] q_sat  = (div_quo[31:24] != 8'h00) ? 24'hFF_FFFF :
			div_quo[23:0];
		wire        over_n = 32'(m_reg) > 32'(lvl);
		wire        hold_n = 32'(m_reg) * RATIO_SCALE >=
			32'(lvl) * RESET_PCT;
		wire        pick_n = ~off &
			(over_reg | (pick_reg & hold_reg));
		wire        blkd_n = pick_n & (blk | blkd_reg);
		wire        strt_n = pick_n & ~blkd_n;
		wire [18:0] elap_n = ~strt_n ? 19'h0 :
			(elap_reg == MAX_TICKS) ? elap_reg : elap_reg + 19'h1;
		wire        trip_n = strt_n & (elap_n >= dly_reg[g]);
		wire        fen    = glb_reg[GLB_FORCE_BIT];
		wire [1:0]  cond   = to_reg ? COND_TRIP : bo_reg ? COND_BLOCK :
			so_reg ? COND_START : COND_NORMAL;

		hoc_divider u_div (
			.aclk    (aclk),
			.aresetn (aresetn),
			.start   (div_go),
			.num     (div_n),
			.den     (div_d),
			.done    (div_done),
			.quo     (div_quo)
		);

		// Latest harmonic and fundamental per slot
		always_ff @(posedge aclk) begin
			if (!aresetn) begin
				h_reg <= '{default: '0};
				f_reg <= '{default: '0};
			end else if (take) begin
				if (meas_order == horder) h_reg[slot] <= meas_value;
				if (meas_order == ORDER_FUND) f_reg[slot] <= meas_value;
			end
		end

		// Per-phase evaluation; a frame during evaluation is skipped
		always_ff @(posedge aclk) begin
			if (!aresetn) begin
				st_reg   <= S_IDLE;
				ph_reg   <= '0;
				m_reg    <= '0;
				rmax_reg <= '0;
				over_reg <= 1'b0;
				hold_reg <= 1'b0;
			end else begin
				unique case (st_reg)
					S_IDLE: if (meas_frame) begin
						ph_reg   <= '0;
						rmax_reg <= '0;
						over_reg <= 1'b0;
						hold_reg <= 1'b0;
						st_reg   <= S_MEAS;
					end
					S_MEAS: begin
						m_reg  <= 24'(h_reg[ph_reg]);
						st_reg <= pct ? S_MWAIT : S_RAT;
					end
					S_MWAIT: if (div_done) begin
						m_reg  <= q_sat;
						st_reg <= S_RAT;
					end
					S_RAT: begin
						over_reg <= over_reg | over_n;
						hold_reg <= hold_reg | hold_n;
						st_reg   <= S_RWAIT;
					end
					S_RWAIT: if (div_done) begin
						if (q_sat > rmax_reg) rmax_reg <= q_sat;
						ph_reg <= ph_reg + 2'h1;
						st_reg <= (ph_reg == last) ? S_DEC : S_MEAS;
					end
					S_DEC: st_reg <= S_IDLE;
				endcase
			end
		end

		// Decision once per frame
		always_ff @(posedge aclk) begin
			if (!aresetn) begin
				pick_reg   <= 1'b0;
				blkd_reg   <= 1'b0;
				start_reg  <= 1'b0;
				trip_reg   <= 1'b0;
				elap_reg   <= '0;
				ratio_reg  <= '0;
				expect_reg <= DLY_RST;
			end else if (st_reg == S_DEC) begin
				pick_reg   <= pick_n;
				blkd_reg   <= blkd_n;
				start_reg  <= strt_n;
				trip_reg   <= trip_n;
				elap_reg   <= elap_n;
				ratio_reg  <= rmax_reg;
				expect_reg <= dly_reg[g];
			end
		end

		// Forcing overrides the outputs, not the evaluation
		always_ff @(posedge aclk) begin
			if (!aresetn) begin
				so_reg <= 1'b0;
				to_reg <= 1'b0;
				bo_reg <= 1'b0;
			end else begin
				so_reg <= fen ? fcode == COND_START : start_reg;
				to_reg <= fen ? fcode == COND_TRIP : trip_reg;
				bo_reg <= fen ? fcode == COND_BLOCK : blkd_reg;
			end
		end

		assign start_out[g]   = so_reg;
		assign trip_out[g]    = to_reg;
		assign blocked_out[g] = bo_reg;
		assign stat_w[g]      = 32'({bo_reg, to_reg, so_reg, emode, cond});
		assign ratio_w[g]     = 32'(ratio_reg);
		assign remain_w[g]    = start_reg ? 32'(signed'({1'b0, dly_reg[g]}) -
			signed'({1'b0, elap_reg})) : 32'h0;
		assign expect_w[g]    = 32'(expect_reg);
	end
endmodule // harmonic_overcurrent_block
`default_nettype wire

// file: harmonic_overcurrent_stage_bench.sv
// Self-checking bench for the harmonic overcurrent block.
// Assumes the front end model and the bound checker are compiled first.
`timescale 1ns/1ns
`default_nettype none
module harmonic_overcurrent_stage_bench
	import hoc_pkg::*;
();
	logic aclk;
	logic aresetn = 1'h0;
	logic s_axi_awvalid = 1'h0, s_axi_wvalid = 1'h0, s_axi_bready = 1'h0;
	logic s_axi_arvalid = 1'h0, s_axi_rready = 1'h0, go = 1'h0;
	logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready;
	logic s_axi_rvalid, meas_valid, meas_side, meas_frame;
	logic [7:0] s_axi_awaddr = 8'h00, s_axi_araddr = 8'h00;
	logic [31:0] s_axi_wdata = 32'h0, s_axi_rdata, d;
	logic [3:0] s_axi_wstrb = 4'hF, block_in = 4'h0;
	logic [3:0] start_out, trip_out, blocked_out;
	logic [1:0] s_axi_bresp, s_axi_rresp, r;
	logic [2:0] meas_chan;
	logic [4:0] meas_order;
	logic [15:0] meas_value, harm = 16'h0000;
	logic [7:0] ra[6] = '{8'h00, 8'h04, 8'h08, 8'h0C, 8'h80, 8'h20};
	logic [31:0] rv[6] = '{32'h100, 32'h14, 32'h7D0, 32'h14, 32'h0, 32'h100};
	int mismatches = 0, comparisons = 0;

	harmonic_overcurrent_block u_dut (.aclk, .aresetn, .s_axi_awaddr,
		.s_axi_awvalid, .s_axi_awready, .s_axi_wdata, .s_axi_wstrb,
		.s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid,
		.s_axi_bready, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready,
		.s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready,
		.meas_valid, .meas_side, .meas_chan, .meas_order, .meas_value,
		.meas_frame, .block_in, .start_out, .trip_out, .blocked_out);
	hoc_front_end u_fe (.aclk, .aresetn, .go, .harm, .meas_valid,
		.meas_side, .meas_chan, .meas_order, .meas_value, .meas_frame);

	initial begin
		aclk = 1'h0;
		forever #25 aclk = ~aclk;
	end
	// -------------------------------------------------------------------
	// Tasks
	// -------------------------------------------------------------------
	task give_verdict;
		$display("mismatches %0d comparisons %0d", mismatches, comparisons);
		if (mismatches == 0 && comparisons > 0)
			$display("Test passed");
		else
			$display("Test failed");
		$finish;
	endtask
	task check(input logic [31:0] got, input logic [31:0] exp);
		comparisons++;
		if (got !== exp) begin
			mismatches++;
			$display("[ERR] %0t got %h expected %h", $time, got, exp);
		end
	endtask
	task automatic bus_wr(input logic [7:0] a, input logic [31:0] v);
		int n;
		@(posedge aclk);
		{s_axi_awaddr, s_axi_wdata} <= {a, v};
		{s_axi_awvalid, s_axi_wvalid} <= 2'h3;
		for (n = 0; n < 100 && !s_axi_bvalid; n++) begin
			@(posedge aclk);
			if (s_axi_awready) s_axi_awvalid <= 1'h0;
			if (s_axi_wready) s_axi_wvalid <= 1'h0;
		end
		// Late ready leaves the response standing for a cycle
		s_axi_bready <= 1'h1;
		@(posedge aclk);
		s_axi_bready <= 1'h0;
		if (n == 100) begin mismatches++; give_verdict; end
	endtask
	task automatic bus_rd(input logic [7:0] a);
		int n;
		@(posedge aclk);
		s_axi_araddr <= a;
		s_axi_arvalid <= 1'h1;
		for (n = 0; n < 100 && !s_axi_rvalid; n++) begin
			@(posedge aclk);
			if (s_axi_arready) s_axi_arvalid <= 1'h0;
		end
		s_axi_rready <= 1'h1;
		@(posedge aclk);
		{d, r} = {s_axi_rdata, s_axi_rresp};
		s_axi_rready <= 1'h0;
		if (n == 100) begin mismatches++; give_verdict; end
	endtask
	// Decision lands within 221 clocks of the frame pulse
	task frame(input logic [15:0] h);
		@(posedge aclk);
		{harm, go} <= {h, 1'h1};
		@(posedge aclk);
		go <= 1'h0;
		repeat (300) @(posedge aclk);
	endtask
	// -------------------------------------------------------------------
	// Sequence
	// -------------------------------------------------------------------
	initial begin
		repeat (5) @(posedge aclk);
		aresetn <= 1'h1;
		for (int i = 0; i < 6; i++) begin
			bus_rd(ra[i]);
			check(d, rv[i]);
		end
		bus_rd(8'h84);
		check(r, RESP_SLVERR);
		bus_wr(8'h40, 32'h101);
		bus_wr(8'h60, 32'h103);
		block_in <= 4'h2;
		frame(16'h001E);
		check(start_out, 4'h5);
		check(blocked_out, 4'h2);
		bus_rd(OFF_STAT);
		check(d, 32'h25);
		bus_rd(OFF_RATIO);
		check(d, 32'h96);
		bus_rd(OFF_EXPECT);
		check(d, 32'h14);
		bus_rd(OFF_REMAIN);
		check(d, 32'h13);
		frame(16'h0014);
		check(start_out, 4'h5);
		block_in <= 4'h0;
		frame(16'h0013);
		check(start_out | blocked_out, 4'h4);
		// Node modes first, forcing only once the frame has been judged
		bus_wr(OFF_GLOBAL, 32'h1);
		bus_wr(8'h40, 32'h501);
		bus_wr(8'h60, 32'h1103);
		frame(16'h001E);
		check(start_out[2:0], 3'h3);
		check(trip_out, 4'h0);
		bus_rd(8'h50);
		check(d, 32'h14);
		bus_wr(OFF_GLOBAL, 32'h3);
		bus_rd(8'h70);
		check(d, 32'h46);
		check(trip_out | start_out, 4'h8);
		give_verdict;
	end
endmodule // harmonic_overcurrent_stage_bench
`default_nettype wire

// file: hoc_checker.sv
// Port assertions for the harmonic overcurrent block.
// Assumes it is bound to the block and sees only its ports.
`timescale 1ns/1ns
`default_nettype none
module hoc_checker
	import hoc_pkg::*;
(
	// Clock and reset
	input wire logic              aclk,
	input wire logic              aresetn,
	// Register bus
	input wire logic              s_axi_awvalid,
	input wire logic              s_axi_awready,
	input wire logic              s_axi_wvalid,
	input wire logic              s_axi_wready,
	input wire logic [1:0]        s_axi_bresp,
	input wire logic              s_axi_bvalid,
	input wire logic              s_axi_bready,
	input wire logic              s_axi_arvalid,
	input wire logic              s_axi_arready,
	input wire logic [31:0]       s_axi_rdata,
	input wire logic [1:0]        s_axi_rresp,
	input wire logic              s_axi_rvalid,
	input wire logic              s_axi_rready,
	// Stage pins
	input wire logic [NSTAGE-1:0] block_in,
	input wire logic [NSTAGE-1:0] start_out,
	input wire logic [NSTAGE-1:0] blocked_out
);
	default clocking cb @(posedge aclk); endclocking
	default disable iff (!aresetn);

	a_start_blk_excl: assert property ((start_out & blocked_out) == '0)
		else $error("start and blocked high together");
	a_start_free: assert property ($rose(start_out[1]) |-> !$past(block_in[1], 6))
		else $error("start rose while blocking was active");
	a_b_answer: assert property (s_axi_awvalid && s_axi_awready && s_axi_wvalid
		&& s_axi_wready |-> ##[1:2] s_axi_bvalid)
		else $error("write response late");
	a_ar_answer: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
		else $error("read data late");
	a_b_hold: assert property (s_axi_bvalid && !s_axi_bready
		|=> s_axi_bvalid && $stable(s_axi_bresp))
		else $error("write response dropped");
	a_r_hold: assert property (s_axi_rvalid && !s_axi_rready
		|=> s_axi_rvalid && $stable(s_axi_rdata) && $stable(s_axi_rresp))
		else $error("read data dropped");
	a_b_clear: assert property (s_axi_bvalid && s_axi_bready |=> !s_axi_bvalid)
		else $error("write response repeated");
	a_ar_busy: assert property (s_axi_rvalid |-> !s_axi_arready)
		else $error("address taken while data pending");
	a_rresp_legal: assert property (s_axi_rvalid |-> s_axi_rresp == RESP_OKAY
		|| s_axi_rresp == RESP_SLVERR)
		else $error("illegal read response");
endmodule // hoc_checker

bind harmonic_overcurrent_block hoc_checker u_chk (.aclk, .aresetn,
	.s_axi_awvalid, .s_axi_awready, .s_axi_wvalid, .s_axi_wready,
	.s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_arvalid,
	.s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid,
	.s_axi_rready, .block_in, .start_out, .blocked_out);
`default_nettype wire

// file: hoc_divider.sv
// Restoring 32 by 16 unsigned divider, one quotient bit per clock.
// Division by zero saturates the quotient to all ones.
`timescale 1ns/1ns
`default_nettype none
module hoc_divider (
	// Clock and reset
	input  wire logic        aclk,
	input  wire logic        aresetn,
	// Operands
	input  wire logic        start,
	input  wire logic [31:0] num,
	input  wire logic [15:0] den,
	// Result
	output var  logic        done,
	output var  logic [31:0] quo
);
	logic [31:0] q_reg;
	logic [15:0] r_reg;
	logic [15:0] d_reg;
	logic [5:0]  cnt_reg;
	logic        done_reg;
	logic [16:0] trial;
	logic        fits;

	assign trial = {r_reg, q_reg[31]};
	assign fits  = trial >= {1'b0, d_reg};

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			q_reg    <= '0;
			r_reg    <= '0;
			d_reg    <= '0;
			cnt_reg  <= '0;
			done_reg <= 1'b0;
		end else if (start) begin
			q_reg    <= num;
			r_reg    <= '0;
			d_reg    <= den;
			cnt_reg  <= 6'd32;
			done_reg <= 1'b0;
		end else begin
			done_reg <= cnt_reg == 6'd1;
			if (cnt_reg != 6'd0) begin
				cnt_reg <= cnt_reg - 6'd1;
				q_reg   <= {q_reg[30:0], fits};
				r_reg   <= fits ? 16'(trial - {1'b0, d_reg}) : trial[15:0];
			end
		end
	end
	assign done = done_reg;
	assign quo  = q_reg;
endmodule // hoc_divider
`default_nettype wire

// file: hoc_front_end.sv
// Measurement front end model: one frame of phase values per go pulse.
// Assumes go is pulsed at most once per 250 clocks.
`timescale 1ns/1ns
`default_nettype none
module hoc_front_end
	import hoc_pkg::*;
(
	// Clock, reset and control
	input  wire logic        aclk,
	input  wire logic        aresetn,
	input  wire logic        go,
	input  wire logic [15:0] harm,
	// Measurement stream
	output var  logic        meas_valid,
	output var  logic        meas_side,
	output var  logic [2:0]  meas_chan,
	output var  logic [4:0]  meas_order,
	output var  logic [15:0] meas_value,
	output var  logic        meas_frame
);
	logic [2:0] step;
	// Idle lines toggle so a stale value is never mistaken for data
	always @(posedge aclk) begin
		meas_valid <= 1'h0;
		meas_frame <= 1'h0;
		{meas_side, meas_chan} <= ~{meas_side, meas_chan};
		{meas_order, meas_value} <= ~{meas_order, meas_value};
		if (!aresetn) begin
			{meas_side, meas_chan, meas_order, meas_value} <= '0;
			step <= 3'h7;
		end else if (go)
			step <= 3'h0;
		else if (step < 3'h6) begin
			meas_valid <= 1'h1;
			meas_side <= 1'h0;
			meas_chan <= {1'h0, step[2:1]};
			meas_order <= step[0] ? 5'h02 : ORDER_FUND;
			meas_value <= step[0] ? (step == 3'h1 ? harm : 16'h0000) : 16'h0032;
			step <= step + 3'h1;
		end else if (step == 3'h6) begin
			meas_frame <= 1'h1;
			step <= 3'h7;
		end
	end
endmodule // hoc_front_end
`default_nettype wire

// file: hoc_pkg.sv
// Constants, register map and codes of the harmonic overcurrent block.
// Assumes one 20 MHz clock and measurement frames every 5 ms.

package hoc_pkg;
	localparam int NSTAGE = 4;
	localparam int ADDR_W = 8;
	// -------------------------------------------------------------------
	// Register map
	// -------------------------------------------------------------------
	localparam logic [7:0] OFF_CFG    = 8'h00;
	localparam logic [7:0] OFF_PU     = 8'h04;
	localparam logic [7:0] OFF_PCT    = 8'h08;
	localparam logic [7:0] OFF_DLY    = 8'h0C;
	localparam logic [7:0] OFF_STAT   = 8'h10;
	localparam logic [7:0] OFF_RATIO  = 8'h14;
	localparam logic [7:0] OFF_REMAIN = 8'h18;
	localparam logic [7:0] OFF_EXPECT = 8'h1C;
	localparam logic [7:0] OFF_GLOBAL = 8'h80;
	// Configuration fields
	localparam int CFG_PCT_BIT   = 0;
	localparam int CFG_HARM_LSB  = 1;
	localparam int CFG_INP_LSB   = 5;
	localparam int CFG_SIDE_BIT  = 7;
	localparam int CFG_MODE_LSB  = 8;
	localparam int CFG_FORCE_LSB = 11;
	localparam int GLB_MODE_BIT  = 0;
	localparam int GLB_FORCE_BIT = 1;
	localparam int ST_COND_LSB   = 0;
	localparam int ST_BEH_LSB    = 2;
	localparam int ST_OUT_LSB    = 5;
	// Reset values
	localparam logic [31:0] CFG_RST = 32'h0000_0100;
	localparam logic [15:0] PU_RST  = 16'h0014;
	localparam logic [15:0] PCT_RST = 16'h07D0;
	localparam logic [18:0] DLY_RST = 19'h00014;
	localparam logic [1:0]  GLB_RST = 2'h0;
	// Setting limits, hundredths
	localparam logic [15:0] PU_MIN  = 16'h0005;
	localparam logic [15:0] PU_MAX  = 16'h00C8;
	localparam logic [15:0] PCT_MIN = 16'h01F4;
	localparam logic [15:0] PCT_MAX = 16'h4E20;
	// Scaling
	localparam logic [31:0] RATIO_SCALE = 32'd100;
	localparam logic [31:0] PCT_SCALE   = 32'd10000;
	localparam logic [31:0] RESET_PCT   = 32'd97;
	// Timing: one timer tick per 5 ms frame, up to 1800 s
	localparam int TICK_US    = 5000;
	localparam int MAX_TIME_S = 1800;
	localparam logic [18:0] MAX_TICKS = 19'(MAX_TIME_S * 1000000 / TICK_US);
	// Node modes and conditions
	localparam logic [2:0] MODE_ON   = 3'h1;
	localparam logic [2:0] MODE_BLK  = 3'h2;
	localparam logic [2:0] MODE_TBLK = 3'h4;
	localparam logic [2:0] MODE_OFF  = 3'h5;
	localparam logic [1:0] COND_NORMAL = 2'h0;
	localparam logic [1:0] COND_START  = 2'h1;
	localparam logic [1:0] COND_TRIP   = 2'h2;
	localparam logic [1:0] COND_BLOCK  = 2'h3;
	// Inputs and channels
	localparam logic [1:0] INP_PHASE = 2'h0;
	localparam logic [1:0] INP_RES1  = 2'h1;
	localparam logic [2:0] CH_L3     = 3'h2;
	localparam logic [2:0] CH_RES1   = 3'h3;
	localparam logic [2:0] CH_RES2   = 3'h4;
	localparam logic [4:0] ORDER_FUND = 5'h01;
	localparam logic [1:0] RESP_OKAY   = 2'h0;
	localparam logic [1:0] RESP_SLVERR = 2'h2;

	typedef enum logic [2:0] {
		S_IDLE, S_MEAS, S_MWAIT, S_RAT, S_RWAIT, S_DEC
	} eval_e;

	function automatic logic [4:0] harm_order(input logic [3:0] idx);
		unique case (idx)
			4'h1: harm_order = 5'h03;
			4'h2: harm_order = 5'h04;
			4'h3: harm_order = 5'h05;
			4'h4: harm_order = 5'h07;
			4'h5: harm_order = 5'h0B;
			4'h6: harm_order = 5'h0D;
			4'h7: harm_order = 5'h0F;
			4'h8: harm_order = 5'h11;
			4'h9: harm_order = 5'h13;
			default: harm_order = 5'h02;
		endcase
	endfunction
endpackage

// file: hoc_sync.sv
// Three-stage synchroniser for external level inputs.
// Assumes inputs are asynchronous to aclk.
`timescale 1ns/1ns
`default_nettype none
module hoc_sync #(
	parameter int W = 4
) (
	// Clock and reset
	input  wire logic         aclk,
	input  wire logic         aresetn,
	// Levels
	input  wire logic [W-1:0] din,
	output var  logic [W-1:0] dout
);
	logic [W-1:0] s1_reg;
	logic [W-1:0] s2_reg;
	logic [W-1:0] s3_reg;
	logic [W-1:0] out_reg;

	// Output follows only once two later stages agree
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			s1_reg  <= '0;
			s2_reg  <= '0;
			s3_reg  <= '0;
			out_reg <= '0;
		end else begin
			s1_reg <= din;
			s2_reg <= s1_reg;
			s3_reg <= s2_reg;
			for (int i = 0; i < W; i++) begin
				if (s2_reg[i] == s3_reg[i]) begin
					out_reg[i] <= s3_reg[i];
				end
			end
		end
	end
	assign dout = out_reg;
endmodule // hoc_sync
`default_nettype wire
